// ===== hdl/sfmr_buf.sv
// two-entry byte buffer with registered outputs
`timescale 1ns/1ps
module sfmr_buf (
  // clock and reset
  input  wire logic  clk_in,
  input  wire logic  rstn_in,
  // both sides of the buffer
  sfmr_buf_if.store  bus
);

  logic [7:0] head;
  logic [7:0] tail;
  logic       head_v;
  logic       tail_v;

  wire logic push = bus.in_valid & bus.in_ready;
  wire logic pop  = head_v & bus.out_ready;

  // head always holds the oldest byte so the outputs need no mux
  wire logic [7:0] next_head   = pop ? (tail_v ? tail : bus.in_data) : (head_v ? head : bus.in_data);
  wire logic       next_head_v = pop ? (tail_v | push) : (head_v | push);
  wire logic       next_tail_v = pop ? 1'b0 : (tail_v | (push & head_v));

  assign bus.in_ready  = ~tail_v;
  assign bus.out_valid = head_v;
  assign bus.out_data  = head;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      head   <= 8'h00;
      tail   <= 8'h00;
      head_v <= 1'b0;
      tail_v <= 1'b0;
    end else begin
      head   <= next_head;
      head_v <= next_head_v;
      tail_v <= next_tail_v;
      if (push & head_v & ~pop) begin
        tail <= bus.in_data;
      end
    end
  end

  chk_buf_order: assert property (@(posedge clk_in) disable iff (!rstn_in)
    tail_v |-> head_v) else $error("buffer tail holds a byte while head is empty");

endmodule // sfmr_buf

// ===== hdl/sfmr_buf_if.sv
// handshake bundle between the sequencer and its read data buffer
`timescale 1ns/1ps
interface sfmr_buf_if;
  logic       in_valid;
  logic       in_ready;
  logic [7:0] in_data;
  logic       out_valid;
  logic       out_ready;
  logic [7:0] out_data;

  modport filler (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
  modport store  (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface

// ===== hdl/sfmr_pkg.sv
// constants, states and helpers for the mapped flash read sequencer
package sfmr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_OPCODE = 8'h00;
  localparam logic [7:0] OFS_PHASE  = 8'h04;
  localparam logic [7:0] OFS_OPTION = 8'h08;
  localparam logic [7:0] OFS_WAIT   = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // field positions
  localparam int OPC_LSB     = 16;
  localparam int CMDW_LSB    = 30;
  localparam int ADRW_LSB    = 24;
  localparam int OPTW_LSB    = 20;
  localparam int RDW_LSB     = 16;
  localparam int WAIT_ON_BIT = 15;
  localparam int ASZ_LSB     = 8;
  localparam int OSEL_LSB    = 4;
  localparam int WAITW_LSB   = 16;
  localparam int WCNT_LSB    = 0;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DATA   = 1;

  // reset values
  localparam logic [31:0] OPCODE_RST = 32'h0003_0000;
  localparam logic [31:0] PHASE_RST  = 32'h0000_0000;
  localparam logic [31:0] OPTION_RST = 32'h0000_0000;
  localparam logic [31:0] WAIT_RST   = 32'h0000_0000;

  // field encodings
  localparam logic [1:0] LANE_FOUR = 2'h2;
  localparam logic [3:0] ASZ_32    = 4'hF;
  localparam logic [3:0] OSEL_1    = 4'h8;
  localparam logic [3:0] OSEL_2    = 4'hC;
  localparam logic [3:0] OSEL_3    = 4'hE;
  localparam logic [3:0] OSEL_4    = 4'hF;

  // phase lengths in bits
  localparam logic [5:0] CMD_BITS   = 6'h08;
  localparam logic [5:0] ADR24_BITS = 6'h18;
  localparam logic [5:0] ADR32_BITS = 6'h20;
  localparam logic [5:0] DATA_BITS  = 6'h20;

  // lane drive patterns and byte assembly
  localparam logic [3:0] OE_ONE   = 4'h1;
  localparam logic [3:0] OE_ALL   = 4'hF;
  localparam logic [3:0] OE_NONE  = 4'h0;
  localparam logic [2:0] NIB_DONE = 3'h4;
  localparam logic [2:0] BIT_DONE = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_CMD, ST_ADDR, ST_OPT, ST_WAIT, ST_DATA, ST_END
  } sfmr_state_t;

  function automatic logic [2:0] opt_count(input logic [3:0] sel);
    opt_count = (sel == OSEL_4) ? 3'h4 :
                (sel == OSEL_3) ? 3'h3 :
                (sel == OSEL_2) ? 3'h2 :
                (sel == OSEL_1) ? 3'h1 : 3'h0;
  endfunction

  function automatic logic [5:0] lane_clocks(input logic [5:0] bits, input logic four);
    lane_clocks = four ? {2'h0, bits[5:2]} : bits;
  endfunction

  function automatic logic [3:0] lane_oe(input sfmr_state_t st, input logic four);
    unique case (st)
      ST_CMD, ST_ADDR, ST_OPT: lane_oe = four ? OE_ALL : OE_ONE;
      ST_WAIT:                 lane_oe = four ? OE_NONE : OE_ONE;
      default:                 lane_oe = OE_NONE;
    endcase
  endfunction

endpackage

// ===== hdl/sfmr_top.sv
// mapped read sequencer: turns a word read into a serial flash read frame
//
// What this block does
// - command phase sends the programmed 8-bit read opcode
// - command phase uses one or four lines per its width field
// - four programmable option bytes, three down to zero
// - option select sends none, or bytes from three downward, up to four
// - option bytes go out on one or four lines per their width field
// - wait phase lasts one to eight serial clocks from a 3-bit count
// - wait phase appears only when its enable bit is set
// - wait phase lane width follows its width field
// - read data sampled on one or four lines per its width field
// - address sent as 24 or 32 bits per address size select
// - address phase uses one or four lines per its width field
`timescale 1ns/1ps
module sfmr_top (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // mapped read request
  input  wire logic        rd_req_valid_in,
  input  wire logic [31:0] rd_req_addr_in,
  output logic             rd_req_ready_out,
  // read data stream
  output logic      [7:0]  rd_data_out,
  output logic             rd_data_valid_out,
  input  wire logic        rd_data_ready_in,
  // serial flash pins
  input  wire logic        serial_clock_ref_in,
  output logic             serial_flash_clock_out,
  output logic             flash_cs_n_out,
  input  wire logic [3:0]  flash_io_in,
  output logic      [3:0]  flash_io_out,
  output logic      [3:0]  flash_io_oe_out
);

  // software registers
  logic [31:0] read_opcode_setting;
  logic [31:0] read_phase_enable;
  logic [31:0] read_option_bytes;
  logic [31:0] read_dummy_setting;

  // sequencer state
  sfmr_pkg::sfmr_state_t state;
  logic [4:0]  clk_left;
  logic [31:0] shreg;
  logic        lane4;
  logic [31:0] addr_q;
  logic [7:0]  rx;
  logic [2:0]  rx_cnt;

  // synchronisers
  logic       ref_s1;
  logic       ref_s2;
  logic       ref_s3;
  logic [3:0] io_s1;
  logic [3:0] io_s2;

  sfmr_buf_if buf_if ();

  sfmr_buf u_buf (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .bus     (buf_if.store)
  );

  // field decode
  wire logic [7:0] opcode     = read_opcode_setting[sfmr_pkg::OPC_LSB +: 8];
  wire logic       cmd_four   = read_phase_enable[sfmr_pkg::CMDW_LSB +: 2] == sfmr_pkg::LANE_FOUR;
  wire logic       addr_four  = read_phase_enable[sfmr_pkg::ADRW_LSB +: 2] == sfmr_pkg::LANE_FOUR;
  wire logic       opt_four   = read_phase_enable[sfmr_pkg::OPTW_LSB +: 2] == sfmr_pkg::LANE_FOUR;
  wire logic       read_four  = read_phase_enable[sfmr_pkg::RDW_LSB +: 2] == sfmr_pkg::LANE_FOUR;
  wire logic       wait_on    = read_phase_enable[sfmr_pkg::WAIT_ON_BIT];
  wire logic       addr32     = read_phase_enable[sfmr_pkg::ASZ_LSB +: 4] == sfmr_pkg::ASZ_32;
  wire logic [3:0] opt_sel    = read_phase_enable[sfmr_pkg::OSEL_LSB +: 4];
  wire logic       wait_four  = read_dummy_setting[sfmr_pkg::WAITW_LSB +: 2] == sfmr_pkg::LANE_FOUR;
  wire logic [2:0] wait_count = read_dummy_setting[sfmr_pkg::WCNT_LSB +: 3];
  wire logic [2:0] opt_n      = sfmr_pkg::opt_count(opt_sel);

  // edges of the reference clock, seen through the synchroniser
  wire logic tick_rise = ref_s2 & ~ref_s3;
  wire logic tick_fall = ~ref_s2 & ref_s3;

  wire logic active = (state == sfmr_pkg::ST_CMD) || (state == sfmr_pkg::ST_ADDR) ||
                      (state == sfmr_pkg::ST_OPT) || (state == sfmr_pkg::ST_WAIT) ||
                      (state == sfmr_pkg::ST_DATA);
  wire logic in_data = state == sfmr_pkg::ST_DATA;

  // request hand-off
  wire logic take_req = (state == sfmr_pkg::ST_IDLE) && rd_req_valid_in && rd_req_ready_out;

  // phase order
  wire sfmr_pkg::sfmr_state_t after_opt  = wait_on ? sfmr_pkg::ST_WAIT : sfmr_pkg::ST_DATA;
  wire sfmr_pkg::sfmr_state_t after_addr = (opt_n != 3'h0) ? sfmr_pkg::ST_OPT : after_opt;
  wire sfmr_pkg::sfmr_state_t nxt_ph =
    (state == sfmr_pkg::ST_START) ? sfmr_pkg::ST_CMD :
    (state == sfmr_pkg::ST_CMD)   ? sfmr_pkg::ST_ADDR :
    (state == sfmr_pkg::ST_ADDR)  ? after_addr :
    (state == sfmr_pkg::ST_OPT)   ? after_opt :
    (state == sfmr_pkg::ST_WAIT)  ? sfmr_pkg::ST_DATA : sfmr_pkg::ST_END;

  // what the next phase shifts out, MSB first
  wire logic [31:0] addr_word = addr32 ? addr_q : {addr_q[23:0], 8'h00};
  wire logic [31:0] load_sh =
    (nxt_ph == sfmr_pkg::ST_CMD)  ? {opcode, 24'h00_0000} :
    (nxt_ph == sfmr_pkg::ST_ADDR) ? addr_word :
    (nxt_ph == sfmr_pkg::ST_OPT)  ? read_option_bytes : 32'h0000_0000;

  wire logic nxt_four =
    (nxt_ph == sfmr_pkg::ST_CMD)  ? cmd_four :
    (nxt_ph == sfmr_pkg::ST_ADDR) ? addr_four :
    (nxt_ph == sfmr_pkg::ST_OPT)  ? opt_four :
    (nxt_ph == sfmr_pkg::ST_WAIT) ? wait_four :
    read_four;

  wire logic [5:0] addr_bits = addr32 ? sfmr_pkg::ADR32_BITS : sfmr_pkg::ADR24_BITS;
  wire logic [5:0] opt_bits  = {opt_n, 3'h0};
  // wait cycles are serial clocks whatever the lane width
  wire logic [5:0] wait_clks = {3'h0, wait_count} + 6'h01;
  wire logic [5:0] nxt_clks =
    (nxt_ph == sfmr_pkg::ST_CMD)  ? sfmr_pkg::lane_clocks(sfmr_pkg::CMD_BITS, cmd_four) :
    (nxt_ph == sfmr_pkg::ST_ADDR) ? sfmr_pkg::lane_clocks(addr_bits, addr_four) :
    (nxt_ph == sfmr_pkg::ST_OPT)  ? sfmr_pkg::lane_clocks(opt_bits, opt_four) :
    (nxt_ph == sfmr_pkg::ST_WAIT) ? wait_clks :
    sfmr_pkg::lane_clocks(sfmr_pkg::DATA_BITS, read_four);
  wire logic [5:0] load_left6 = nxt_clks - 6'h01;

  // read data assembly
  wire logic       byte_done = read_four ? (rx_cnt == sfmr_pkg::NIB_DONE) : (rx_cnt == sfmr_pkg::BIT_DONE);
  wire logic [7:0] next_rx   = read_four ? {rx[3:0], io_s2} : {rx[6:0], io_s2[1]};
  wire logic [2:0] rx_step   = read_four ? 3'h4 : 3'h1;
  wire logic [2:0] next_rx_cnt = byte_done ? 3'h0 : rx_cnt + rx_step;

  // a full buffer holds the serial clock low, so no byte is dropped
  wire logic stall   = in_data && byte_done && !buf_if.in_ready;
  wire logic rise_ok = tick_rise && active && !serial_flash_clock_out && !stall;
  wire logic fall_ok = tick_fall && ((state == sfmr_pkg::ST_START) || (active && serial_flash_clock_out));
  wire logic leaving = (state == sfmr_pkg::ST_START) || (clk_left == 5'h00);

  // shifting
  wire logic [31:0] shifted  = lane4 ? {shreg[27:0], 4'h0} : {shreg[30:0], 1'b0};
  wire logic [31:0] next_sh  = leaving ? load_sh : shifted;
  wire logic        next_l4  = leaving ? nxt_four : lane4;
  wire logic [3:0]  next_io  = next_l4 ? next_sh[31:28] : {3'h0, next_sh[31]};
  wire logic [3:0]  next_oe  = leaving ? sfmr_pkg::lane_oe(nxt_ph, nxt_four) : flash_io_oe_out;
  wire logic [4:0]  next_left = leaving ? load_left6[4:0] : clk_left - 5'h01;

  wire sfmr_pkg::sfmr_state_t next_state =
    take_req ? sfmr_pkg::ST_START :
    (fall_ok && leaving) ? nxt_ph :
    (state == sfmr_pkg::ST_END) ? sfmr_pkg::ST_IDLE : state;

  // buffer hookup
  assign buf_if.in_valid  = rise_ok && in_data && byte_done;
  assign buf_if.in_data   = next_rx;
  assign buf_if.out_ready = rd_data_ready_in;
  assign rd_data_out       = buf_if.out_data;
  assign rd_data_valid_out = buf_if.out_valid;

  // register decode
  wire logic wr_opcode = reg_wr_in && (reg_addr_in == sfmr_pkg::OFS_OPCODE);
  wire logic wr_phase  = reg_wr_in && (reg_addr_in == sfmr_pkg::OFS_PHASE);
  wire logic wr_option = reg_wr_in && (reg_addr_in == sfmr_pkg::OFS_OPTION);
  wire logic wr_wait   = reg_wr_in && (reg_addr_in == sfmr_pkg::OFS_WAIT);

  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[sfmr_pkg::STAT_BUSY] = state != sfmr_pkg::ST_IDLE;
    stat_word[sfmr_pkg::STAT_DATA] = buf_if.out_valid;
  end

  wire logic [31:0] rd_mux =
    (reg_addr_in == sfmr_pkg::OFS_OPCODE) ? read_opcode_setting :
    (reg_addr_in == sfmr_pkg::OFS_PHASE)  ? read_phase_enable :
    (reg_addr_in == sfmr_pkg::OFS_OPTION) ? read_option_bytes :
    (reg_addr_in == sfmr_pkg::OFS_WAIT)   ? read_dummy_setting :
    (reg_addr_in == sfmr_pkg::OFS_STATUS) ? stat_word : 32'h0000_0000;

  // a setting changed mid-frame takes effect at the next phase boundary, except the read width, which byte assembly follows at once
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      read_opcode_setting <= sfmr_pkg::OPCODE_RST;
      read_phase_enable   <= sfmr_pkg::PHASE_RST;
      read_option_bytes   <= sfmr_pkg::OPTION_RST;
      read_dummy_setting  <= sfmr_pkg::WAIT_RST;
    end else begin
      if (wr_opcode) read_opcode_setting <= reg_wdata_in;
      if (wr_phase)  read_phase_enable   <= reg_wdata_in;
      if (wr_option) read_option_bytes   <= reg_wdata_in;
      if (wr_wait)   read_dummy_setting  <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_s1 <= 1'b0;
      ref_s2 <= 1'b0;
      ref_s3 <= 1'b0;
      io_s1  <= 4'h0;
      io_s2  <= 4'h0;
    end else begin
      ref_s1 <= serial_clock_ref_in;
      ref_s2 <= ref_s1;
      ref_s3 <= ref_s2;
      io_s1  <= flash_io_in;
      io_s2  <= io_s1;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state  <= sfmr_pkg::ST_IDLE;
      addr_q <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (take_req) addr_q <= rd_req_addr_in;
    end
  end

  // serial clock and select
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_flash_clock_out <= 1'b0;
      flash_cs_n_out         <= 1'b1;
      rd_req_ready_out       <= 1'b0;
    end else begin
      if (rise_ok) serial_flash_clock_out <= 1'b1;
      else if (fall_ok) serial_flash_clock_out <= 1'b0;
      if (fall_ok && state == sfmr_pkg::ST_START) flash_cs_n_out <= 1'b0;
      else if (state == sfmr_pkg::ST_END) flash_cs_n_out <= 1'b1;
      rd_req_ready_out <= (next_state == sfmr_pkg::ST_IDLE);
    end
  end

  // output shifter, updated on the falling serial edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shreg           <= 32'h0000_0000;
      lane4           <= 1'b0;
      clk_left        <= 5'h00;
      flash_io_out    <= 4'h0;
      flash_io_oe_out <= 4'h0;
    end else if (fall_ok) begin
      shreg           <= next_sh;
      lane4           <= next_l4;
      clk_left        <= next_left;
      flash_io_out    <= next_io;
      flash_io_oe_out <= next_oe;
    end
  end

  // input capture, on the rising serial edge
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx     <= 8'h00;
      rx_cnt <= 3'h0;
    end else if (take_req) begin
      rx_cnt <= 3'h0;
    end else if (rise_ok && in_data) begin
      rx     <= next_rx;
      rx_cnt <= next_rx_cnt;
    end
  end

  // helper: serial clocks seen in the current phase
  logic [5:0] ph_rises;
  logic [5:0] ph_expect;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ph_rises  <= 6'h00;
      ph_expect <= 6'h00;
    end else if (fall_ok && leaving) begin
      ph_rises  <= 6'h00;
      ph_expect <= nxt_clks;
    end else if (rise_ok) begin
      ph_rises  <= ph_rises + 6'h01;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  sequence s_frame_open;
    $fell(flash_cs_n_out);
  endsequence
  sequence s_opcode_lead;
    state == sfmr_pkg::ST_CMD &&
    (cmd_four ? flash_io_out == opcode[7:4] : flash_io_out[0] == opcode[7]);
  endsequence
  sequence s_frame_close;
    state == sfmr_pkg::ST_END;
  endsequence
  sequence s_released;
    flash_cs_n_out && flash_io_oe_out == sfmr_pkg::OE_NONE ##1 rd_req_ready_out;
  endsequence

  chk_cmd_first: assert property (s_frame_open |-> s_opcode_lead)
    else $error("frame does not open with the opcode");
  chk_cmd_lanes: assert property (state == sfmr_pkg::ST_CMD |->
    flash_io_oe_out == (cmd_four ? sfmr_pkg::OE_ALL : sfmr_pkg::OE_ONE))
    else $error("command phase lane drive wrong");
  chk_opt_first: assert property ($rose(state == sfmr_pkg::ST_OPT) |->
    shreg == read_option_bytes && (opt_four ? flash_io_out == read_option_bytes[31:28]
    : flash_io_out[0] == read_option_bytes[31]))
    else $error("option phase does not start at byte three");
  chk_opt_skip: assert property ((state == sfmr_pkg::ST_ADDR && opt_n == 3'h0) |=>
    state != sfmr_pkg::ST_OPT)
    else $error("option phase entered with none selected");
  chk_opt_lanes: assert property (state == sfmr_pkg::ST_OPT |->
    flash_io_oe_out == (opt_four ? sfmr_pkg::OE_ALL : sfmr_pkg::OE_ONE))
    else $error("option phase lane drive wrong");
  chk_phase_len: assert property ((fall_ok && leaving && active) |->
    ph_rises == ph_expect)
    else $error("phase ended after the wrong number of serial clocks");
  chk_wait_skip: assert property (state == sfmr_pkg::ST_WAIT |-> wait_on)
    else $error("wait phase inserted while disabled");
  chk_wait_lanes: assert property (state == sfmr_pkg::ST_WAIT |->
    flash_io_oe_out == (wait_four ? sfmr_pkg::OE_NONE : sfmr_pkg::OE_ONE))
    else $error("wait phase lane drive wrong");
  chk_read_lanes: assert property (in_data |-> flash_io_oe_out == sfmr_pkg::OE_NONE)
    else $error("pins driven while reading data");
  chk_addr_len: assert property ($rose(state == sfmr_pkg::ST_ADDR) |->
    ph_expect == (addr32 ? (addr_four ? 6'h08 : 6'h20) : (addr_four ? 6'h06 : 6'h18)))
    else $error("address phase length does not match its size");
  chk_addr_lanes: assert property (state == sfmr_pkg::ST_ADDR |->
    flash_io_oe_out == (addr_four ? sfmr_pkg::OE_ALL : sfmr_pkg::OE_ONE))
    else $error("address phase lane drive wrong");
  chk_frame_end: assert property (s_frame_close |=> s_released)
    else $error("select not released after data phase");
  chk_cs_held: assert property (!flash_cs_n_out |-> active || state == sfmr_pkg::ST_END)
    else $error("select low outside a frame");

endmodule // sfmr_top

// ===== testbench/sfmr_flash_model.sv
// behavioural serial flash that answers one mapped read per frame
`timescale 1ns/1ps
module sfmr_flash_model (
  // flash pins
  input  wire logic        sck_in,
  input  wire logic        cs_n_in,
  output logic      [3:0]  io_out,
  // frame setup from the bench
  input  wire logic [31:0] word_in,
  input  wire logic [7:0]  lead_clks_in,
  input  wire logic        four_in
);
  int k;
  int cnt = 0;
  initial io_out = 4'h0;
  always @(posedge cs_n_in) cnt = 0;
  always @(posedge sck_in) if (!cs_n_in) cnt = cnt + 1;
  // lines not driven keep toggling, so a stale sample never matches by luck
  always @(negedge sck_in or negedge cs_n_in or posedge cs_n_in) begin
    io_out = ~io_out;
    k = cnt - int'(lead_clks_in);
    if (!cs_n_in && k >= 0 && four_in && k < 8) io_out = word_in[31-4*k -: 4];
    if (!cs_n_in && k >= 0 && !four_in && k < 32) io_out[1] = word_in[31-k];
  end
endmodule // sfmr_flash_model

// ===== testbench/tb.sv
// self-checking bench for the mapped flash read sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic        clk_in, rstn_in, reg_wr_in, reg_rd_in, rd_req_valid_in, rd_data_ready_in, ref_clk, hold;
  logic        rd_req_ready_out, rd_data_valid_out, sck, cs_n, four_rd, rd_d, sck_d;
  logic [7:0]  reg_addr_in, rd_data_out, lead;
  logic [31:0] reg_wdata_in, reg_rdata_out, rd_req_addr_in, word, w;
  logic [3:0]  io_in, io_out, io_oe;
  logic [11:0] e;
  logic [11:0] exp_q[$];
  logic [7:0]  byte_q[$];
  logic [31:0] reg_q[$];
  int          n_errors, n_tests;
  localparam logic [3:0] SELS [6] = '{4'h0, sfmr_pkg::OSEL_1, sfmr_pkg::OSEL_2, sfmr_pkg::OSEL_3,
                                      sfmr_pkg::OSEL_4, 4'h3};

  sfmr_top sfmr_top_inst (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .rd_req_valid_in(rd_req_valid_in), .rd_req_addr_in(rd_req_addr_in), .rd_req_ready_out(rd_req_ready_out),
    .rd_data_out(rd_data_out), .rd_data_valid_out(rd_data_valid_out), .rd_data_ready_in(rd_data_ready_in),
    .serial_clock_ref_in(ref_clk), .serial_flash_clock_out(sck), .flash_cs_n_out(cs_n),
    .flash_io_in(io_in), .flash_io_out(io_out), .flash_io_oe_out(io_oe));
  sfmr_flash_model sfmr_flash_model_inst (.sck_in(sck), .cs_n_in(cs_n), .io_out(io_in), .word_in(word),
    .lead_clks_in(lead), .four_in(four_rd));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // odd start offset keeps the link reference unrelated in phase
  initial begin
    ref_clk = 1'b0;
    #7;
    forever #160 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // op 0 idles the port, 1 writes, 2 reads and notes d as the expected word
  task automatic bus(input int op, input logic [7:0] a, input logic [31:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= (op == 1);
    reg_rd_in    <= (op == 2);
    if (op == 2) reg_q.push_back(d);
    @(posedge clk_in);
  endtask

  // expected pin state per serial clock: {enables, data, compare mask}
  task automatic ph(input logic [31:0] v, input int n, input logic four, input logic drv);
    for (int i = 0; i < n; i += (four ? 4 : 1)) begin
      if (!drv) exp_q.push_back(12'h000);
      else if (four) exp_q.push_back({4'hF, v[n-1-i -: 4], 4'hF});
      else exp_q.push_back({4'h1, 3'h0, v[n-1-i], 4'h1});
    end
  endtask

  task automatic frame(input int i);
    logic [1:0]  cw, aw, ow, rw, ww;
    logic [3:0]  asz, sel;
    logic [31:0] op, opt, ad, pr, wt;
    logic        won;
    int          nopt, c, t;
    {cw, aw, ow, rw, ww} = $urandom;
    op   = {8'h0, 8'($urandom), 16'h0};
    opt  = $urandom;
    ad   = $urandom;
    word = $urandom;
    asz  = (i % 2) ? sfmr_pkg::ASZ_32 : 4'($urandom % 15);
    sel  = SELS[i % 6];
    nopt = (i % 6 == 5) ? 0 : i % 6;
    won  = (i % 3 != 0);
    c    = i % 8;
    pr   = {cw, 4'h0, aw, 2'h0, ow, 2'h0, rw, won, 3'h0, asz, sel, 4'h0};
    wt   = {14'h0, ww, 13'h0, 3'(c)};
    bus(1, sfmr_pkg::OFS_OPCODE, op);
    bus(1, sfmr_pkg::OFS_PHASE, pr);
    bus(1, sfmr_pkg::OFS_OPTION, opt);
    bus(1, sfmr_pkg::OFS_WAIT, wt);
    bus(2, sfmr_pkg::OFS_OPCODE, op);
    bus(2, sfmr_pkg::OFS_PHASE, pr);
    bus(2, sfmr_pkg::OFS_OPTION, opt);
    bus(2, sfmr_pkg::OFS_WAIT, wt);
    bus(0, 8'h00, 32'h0);
    ph(op >> 16, 8, cw == sfmr_pkg::LANE_FOUR, 1'b1);
    ph(ad, (asz == sfmr_pkg::ASZ_32) ? 32 : 24, aw == sfmr_pkg::LANE_FOUR, 1'b1);
    ph(opt >> (32 - 8 * nopt), 8 * nopt, ow == sfmr_pkg::LANE_FOUR, 1'b1);
    if (won) ph(32'h0, c + 1, 1'b0, ww != sfmr_pkg::LANE_FOUR);
    lead    = 8'(exp_q.size());
    four_rd = (rw == sfmr_pkg::LANE_FOUR);
    ph(32'h0, 32, four_rd, 1'b0);
    for (int b = 0; b < 4; b++) byte_q.push_back(word[31-8*b -: 8]);
    rd_req_addr_in  <= ad;
    rd_req_valid_in <= 1'b1;
    hold            <= (i % 4 == 3);
    t = 0;
    @(posedge clk_in);
    while (rd_req_ready_out !== 1'b1 && t < 100) begin
      @(posedge clk_in);
      t++;
    end
    rd_req_valid_in <= 1'b0;
    if (hold) begin
      // a stalled reader must freeze the frame, not drop bytes
      repeat (1500) @(posedge clk_in);
      `CHK("stalled cs_n", 1'b0, cs_n)
      bus(2, sfmr_pkg::OFS_STATUS, (32'h1 << sfmr_pkg::STAT_BUSY) | (32'h1 << sfmr_pkg::STAT_DATA));
      bus(0, 8'h00, 32'h0);
      hold <= 1'b0;
    end
    for (c = 0; c < 6000 && (byte_q.size() != 0 || cs_n !== 1'b1 || rd_req_ready_out !== 1'b1); c++)
      @(posedge clk_in);
    if (t >= 100 || c >= 6000) begin
      n_errors++;
      tally_and_finish();
    end
    `CHK("serial clocks left", 0, exp_q.size())
    $display("frame %0d done", i);
  endtask

  always @(posedge clk_in) begin
    sck_d            <= sck;
    rd_d             <= reg_rd_in;
    rd_data_ready_in <= !hold && ($urandom % 4 != 0);
    // pop once: the compare macro names its expected value twice
    if (rd_d) begin
      w = reg_q.pop_front();
      `CHK("reg read", w, reg_rdata_out)
    end
    if (cs_n) `CHK("idle enables", 4'h0, io_oe)
    if (rd_data_valid_out && rd_data_ready_in) begin
      w = byte_q.pop_front();
      `CHK("read byte", w[7:0], rd_data_out)
    end
    if (sck && !sck_d) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 12'hFF0;
      `CHK("pins", e, {io_oe, io_out & e[3:0], e[3:0]})
      `CHK("cs_n in frame", 1'b0, cs_n)
    end
  end

  initial begin
    {rstn_in, reg_wr_in, reg_rd_in, rd_req_valid_in, hold} = 5'h00;
    {reg_addr_in, reg_wdata_in, rd_req_addr_in, word, lead, four_rd} = '0;
    n_errors = 0;
    n_tests  = 0;
    void'($urandom(83449));
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    bus(2, sfmr_pkg::OFS_OPCODE, sfmr_pkg::OPCODE_RST);
    bus(2, sfmr_pkg::OFS_PHASE, sfmr_pkg::PHASE_RST);
    bus(2, sfmr_pkg::OFS_OPTION, sfmr_pkg::OPTION_RST);
    bus(2, sfmr_pkg::OFS_WAIT, sfmr_pkg::WAIT_RST);
    bus(2, sfmr_pkg::OFS_STATUS, 32'h0000_0000);
    bus(1, 8'h14, 32'hFFFF_FFFF);
    bus(2, 8'h14, 32'h0);
    bus(0, 8'h00, 32'h0);
    $display("register reset test done");
    for (int i = 0; i < 16; i++) frame(i);
    tally_and_finish();
  end
endmodule // tb
